// ---- design/dlr_responder.sv ----
// Operation
// [RL1] retrieve answers echo, ten-digit length, comma, ten-digit count, CR LF first
// [RL2] with records stored, first record follows the header without a prompt
// [RL3] every further record waits for one host prompt character
// [RL4] after the last record a five-byte EOF CR LF trailer closes the transfer
// [RL5] byte 0 is the type byte: bit 0 erased, bit 4 after-sleep
// [RL6] bytes 1 to 7 are raw seconds, minutes, hours, weekday, date, month, year
// [RL7] bytes 8 to 11 hold the 32-bit reading, big-endian
// [RL8] bytes 12 and 13 hold the raw 16-bit temperature, big-endian
// [RL9] snow fields std freq, snow reading, snow freq, then four 0xFF bytes
// [RL10] voltage query answers echo and three-digit supply adc value
// [RL11] status query answers echo and three-digit memory status byte
// [RL12] host polls status and waits for busy bit clear after erase
// [RL13] every text answer ends with CR then LF
// [RL14] with no records, count is zero and EOF follows the header at once
`include "dlr_defs.svh"

// ********************************************************
// byte fifo
// ********************************************************
module dlr_fifo #(
   parameter int WIDTH = `DLR_FIFO_WIDTH,
   parameter int DEPTH = `DLR_FIFO_DEPTH
) (
   input  wire logic             clk_sys,
   input  wire logic             rst,
   input  wire logic             in_valid,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  in_ready,
   output logic                  out_valid,
   output logic      [WIDTH-1:0] out_data,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic [AW:0]      cnt, next_cnt;
   logic             full, next_full, next_out_valid;
   logic [WIDTH-1:0] next_out_data;
   logic             wr, rd;

   always_comb
   begin
      wr             = in_valid && !full;
      rd             = out_valid && out_ready;
      next_wr_ptr    = wr ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = rd ? rd_ptr + 1'b1 : rd_ptr;
      next_cnt       = cnt + (AW+1)'(wr) - (AW+1)'(rd);
      next_full      = next_cnt == (AW+1)'(DEPTH);
      next_out_valid = next_cnt != '0;
      // head is registered; a write into the next head slot bypasses mem
      next_out_data  = (wr && next_rd_ptr == wr_ptr) ? in_data : mem[next_rd_ptr];
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         cnt       <= '0;
         full      <= 1'b0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end
      else
      begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         cnt       <= next_cnt;
         full      <= next_full;
         out_valid <= next_out_valid;
         out_data  <= next_out_data;
      end
   end

   for (genvar g = 0; g < DEPTH; g++)
   begin : g_entry
      always_ff @(posedge clk_sys)
      begin
         if (wr && wr_ptr == AW'(g))
            mem[g] <= in_data;
      end
   end

   // full is registered so the producer sees a clean ready
   assign in_ready = !full;
endmodule : dlr_fifo

// ********************************************************
// command responder
// ********************************************************
module dlr_responder (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire dlr_pkg::dlr_byte_type  rx,
   output logic                        tx_valid,
   output logic [7:0]                  tx_data,
   input  wire logic                   tx_ready,
   input  wire logic [31:0]            rec_count,
   output logic                        rec_rd,
   output logic [31:0]                 rec_idx,
   input  wire logic                   rec_valid,
   input  wire dlr_pkg::dlr_record_type rec_in,
   input  wire logic [7:0]             supply_adc,
   input  wire logic [7:0]             mem_status,
   output logic                        transfer_busy
);
   import dlr_pkg::*;

   dlr_state_type  state, next_state;
   dlr_cmd_type    cmd, next_cmd;
   dlr_record_type rec_buf, next_rec_buf;
   logic [15:0] hist, next_hist;
   logic [4:0]  idx, next_idx;
   logic [3:0]  pos, next_pos;
   logic [3:0]  dig, next_dig;
   logic [31:0] val, next_val;
   logic [31:0] count, next_count;
   logic [31:0] next_rec_idx;
   logic        phase, next_phase;
   logic        next_rec_rd;
   logic        next_transfer_busy;
   logic [7:0]  next_last_byte;
   logic        push, push_ready;
   logic [7:0]  push_data, last_byte;
   logic [31:0] pw;

   function automatic logic [31:0] pow10(input logic [3:0] p);
      case (p)
         4'h9:    pow10 = 32'h3B9ACA00;
         4'h8:    pow10 = 32'h05F5E100;
         4'h7:    pow10 = 32'h00989680;
         4'h6:    pow10 = 32'h000F4240;
         4'h5:    pow10 = 32'h000186A0;
         4'h4:    pow10 = 32'h00002710;
         4'h3:    pow10 = 32'h000003E8;
         4'h2:    pow10 = 32'h00000064;
         4'h1:    pow10 = 32'h0000000A;
         default: pow10 = 32'h00000001;
      endcase
   endfunction : pow10

   function automatic logic [7:0] rec_byte(input dlr_record_type r, input logic [4:0] i);
      case (i)
         5'h00:   rec_byte = r.rec_type;              // RL5
         5'h01:   rec_byte = r.seconds;               // RL6
         5'h02:   rec_byte = r.minutes;
         5'h03:   rec_byte = r.hours;
         5'h04:   rec_byte = r.weekday;
         5'h05:   rec_byte = r.date;
         5'h06:   rec_byte = r.month;
         5'h07:   rec_byte = r.year;
         5'h08:   rec_byte = r.reading[31:24];        // RL7
         5'h09:   rec_byte = r.reading[23:16];
         5'h0A:   rec_byte = r.reading[15:8];
         5'h0B:   rec_byte = r.reading[7:0];
         5'h0C:   rec_byte = r.temp[15:8];            // RL8
         5'h0D:   rec_byte = r.temp[7:0];
         5'h10:   rec_byte = r.std_freq[31:24];       // RL9
         5'h11:   rec_byte = r.std_freq[23:16];
         5'h12:   rec_byte = r.std_freq[15:8];
         5'h13:   rec_byte = r.std_freq[7:0];
         5'h14:   rec_byte = r.snow_reading[31:24];
         5'h15:   rec_byte = r.snow_reading[23:16];
         5'h16:   rec_byte = r.snow_reading[15:8];
         5'h17:   rec_byte = r.snow_reading[7:0];
         5'h18:   rec_byte = r.snow_freq[31:24];
         5'h19:   rec_byte = r.snow_freq[23:16];
         5'h1A:   rec_byte = r.snow_freq[15:8];
         5'h1B:   rec_byte = r.snow_freq[7:0];
         5'h0E,
         5'h0F:   rec_byte = `DLR_PAD_BYTE;
         default: rec_byte = `DLR_SPARE_BYTE;         // RL9
      endcase
   endfunction : rec_byte

   always_comb
   begin
      next_state   = state;
      next_cmd     = cmd;
      next_rec_buf = rec_buf;
      next_hist    = hist;
      next_idx     = idx;
      next_pos     = pos;
      next_dig     = dig;
      next_val     = val;
      next_count   = count;
      next_rec_idx = rec_idx;
      next_phase   = phase;
      next_rec_rd  = 1'b0;
      push         = 1'b0;
      push_data    = 8'h00;
      pw           = pow10(pos);
      case (state)
         S_IDLE:
         begin
            if (rx.valid)
            begin
               next_hist = {hist[7:0], rx.data};
               if (rx.data == `DLR_CH_X && hist[15:8] == `DLR_CH_L &&
                   (hist[7:0] == `DLR_CH_8 || hist[7:0] == `DLR_CH_5 ||
                    hist[7:0] == `DLR_CH_6))
               begin
                  next_hist  = 16'h0000;
                  next_idx   = 5'h00;
                  next_state = S_ECHO;
                  next_cmd   = hist[7:0] == `DLR_CH_8 ? C_RETRIEVE :
                               hist[7:0] == `DLR_CH_5 ? C_VOLT : C_STATUS;
               end
            end
         end
         S_ECHO:
         begin
            push      = 1'b1;                                              // RL1
            push_data = idx == 5'h00 ? `DLR_CH_L :
                        idx == 5'h01 ? (cmd == C_RETRIEVE ? `DLR_CH_8 :
                                        cmd == C_VOLT ? `DLR_CH_5 : `DLR_CH_6) :
                        `DLR_CH_COMMA;
            if (push_ready)
            begin
               next_idx = idx + 5'h01;
               if (idx == `DLR_ECHO_LAST)
               begin
                  next_state = S_NUM;
                  next_dig   = 4'h0;
                  next_phase = 1'b0;
                  next_pos   = cmd == C_RETRIEVE ? `DLR_LONG_POS : `DLR_SHORT_POS;
                  next_val   = cmd == C_RETRIEVE ? `DLR_PKT_LEN :
                               cmd == C_VOLT ? {24'h000000, supply_adc} :  // RL10
                               {24'h000000, mem_status};                    // RL11
               end
            end
         end
         S_NUM:
         begin
            // one subtraction per cycle keeps the divider out of the path
            if (val >= pw)
            begin
               next_val = val - pw;
               next_dig = dig + 4'h1;
            end
            else
            begin
               push      = 1'b1;
               push_data = `DLR_CH_0 + {4'h0, dig};
               if (push_ready)
               begin
                  next_dig = 4'h0;
                  next_pos = pos - 4'h1;
                  if (pos == 4'h0)
                     next_state = (cmd == C_RETRIEVE && !phase) ? S_SEP : S_CR;
               end
            end
         end
         S_SEP:
         begin
            push      = 1'b1;
            push_data = `DLR_CH_COMMA;
            if (push_ready)
            begin
               next_state = S_NUM;
               next_val   = rec_count;
               next_count = rec_count;
               next_pos   = `DLR_LONG_POS;
               next_phase = 1'b1;
            end
         end
         S_CR:
         begin
            push      = 1'b1;
            push_data = `DLR_CH_CR;                                        // RL13
            if (push_ready)
               next_state = S_LF;
         end
         S_LF:
         begin
            push      = 1'b1;
            push_data = `DLR_CH_LF;                                        // RL13
            if (push_ready)
            begin
               next_idx = 5'h00;
               if (cmd != C_RETRIEVE)
                  next_state = S_IDLE;
               else if (count == 32'h00000000)
                  next_state = S_EOF;                                      // RL14
               else
               begin
                  next_state   = S_FETCH;                                  // RL2
                  next_rec_idx = 32'h00000000;
                  next_rec_rd  = 1'b1;
               end
            end
         end
         S_FETCH:
         begin
            if (rec_valid)
            begin
               next_rec_buf = rec_in;
               next_idx     = 5'h00;
               next_state   = S_REC;
            end
         end
         S_REC:
         begin
            push      = 1'b1;
            push_data = rec_byte(rec_buf, idx);
            if (push_ready)
            begin
               next_idx = idx + 5'h01;
               if (idx == `DLR_REC_LAST)
               begin
                  next_idx   = 5'h00;
                  next_state = (rec_idx + 32'h00000001 == count) ? S_EOF : S_WAIT;
               end
            end
         end
         S_WAIT:
         begin
            // prompts that arrive before this state are dropped
            if (rx.valid && rx.data == `DLR_CH_X)                          // RL3
            begin
               next_state   = S_FETCH;
               next_rec_idx = rec_idx + 32'h00000001;
               next_rec_rd  = 1'b1;
            end
         end
         S_EOF:
         begin
            push      = 1'b1;                                              // RL4
            push_data = idx == 5'h00 ? `DLR_CH_E :
                        idx == 5'h01 ? `DLR_CH_O :
                        idx == 5'h02 ? `DLR_CH_F :
                        idx == 5'h03 ? `DLR_CH_CR : `DLR_CH_LF;
            if (push_ready)
            begin
               next_idx = idx + 5'h01;
               if (idx == `DLR_EOF_LAST)
                  next_state = S_IDLE;
            end
         end
         default: next_state = S_IDLE;
      endcase
      next_last_byte     = (push && push_ready) ? push_data : last_byte;
      next_transfer_busy = next_state != S_IDLE;
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state         <= S_IDLE;
         cmd           <= C_RETRIEVE;
         rec_buf       <= '0;
         hist          <= 16'h0000;
         idx           <= 5'h00;
         pos           <= 4'h0;
         dig           <= 4'h0;
         val           <= 32'h00000000;
         count         <= 32'h00000000;
         rec_idx       <= 32'h00000000;
         phase         <= 1'b0;
         rec_rd        <= 1'b0;
         last_byte     <= 8'h00;
         transfer_busy <= 1'b0;
      end
      else
      begin
         state         <= next_state;
         cmd           <= next_cmd;
         rec_buf       <= next_rec_buf;
         hist          <= next_hist;
         idx           <= next_idx;
         pos           <= next_pos;
         dig           <= next_dig;
         val           <= next_val;
         count         <= next_count;
         rec_idx       <= next_rec_idx;
         phase         <= next_phase;
         rec_rd        <= next_rec_rd;
         last_byte     <= next_last_byte;
         transfer_busy <= next_transfer_busy;
      end
   end

   dlr_fifo #(
      .WIDTH (`DLR_FIFO_WIDTH),
      .DEPTH (`DLR_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .in_valid  (push),
      .in_data   (push_data),
      .in_ready  (push_ready),
      .out_valid (tx_valid),
      .out_data  (tx_data),
      .out_ready (tx_ready)
   );

   // ********************************************************
   // checks
   // ********************************************************
   property p_echo_l;
      @(posedge clk_sys) disable iff (rst)
      (state == S_ECHO && idx == 5'h00 && push) |-> push_data == `DLR_CH_L;
   endproperty
   a_echo_l: assert property (p_echo_l) else $error("echo must open with L"); // RL1
   property p_auto_first;
      @(posedge clk_sys) disable iff (rst)
      (state == S_LF && push_ready && cmd == C_RETRIEVE && count != 32'h0)
      |=> state == S_FETCH && rec_rd && rec_idx == 32'h0;
   endproperty
   a_auto_first: assert property (p_auto_first) else $error("first record not fetched"); // RL2
   property p_wait_prompt;
      @(posedge clk_sys) disable iff (rst)
      (state == S_WAIT && !(rx.valid && rx.data == `DLR_CH_X)) |=> state == S_WAIT && !rec_rd;
   endproperty
   a_wait_prompt: assert property (p_wait_prompt) else $error("record sent unprompted"); // RL3
   property p_eof;
      @(posedge clk_sys) disable iff (rst)
      (state == S_EOF && idx == 5'h02 && push) |-> push_data == `DLR_CH_F;
   endproperty
   a_eof: assert property (p_eof) else $error("bad end of file trailer"); // RL4
   property p_reading;
      @(posedge clk_sys) disable iff (rst)
      (state == S_REC && idx == 5'h08 && push) |-> push_data == rec_buf.reading[31:24];
   endproperty
   a_reading: assert property (p_reading) else $error("reading not big-endian"); // RL7
   property p_spare;
      @(posedge clk_sys) disable iff (rst)
      (state == S_REC && idx >= `DLR_SPARE_FIRST && push) |-> push_data == `DLR_SPARE_BYTE;
   endproperty
   a_spare: assert property (p_spare) else $error("spare byte not all ones"); // RL9
   property p_digit;
      @(posedge clk_sys) disable iff (rst)
      (state == S_NUM && push) |-> push_data >= `DLR_CH_0 && push_data <= 8'h39;
   endproperty
   a_digit: assert property (p_digit) else $error("non decimal digit sent"); // RL11
   property p_crlf;
      @(posedge clk_sys) disable iff (rst)
      (state == S_LF && push) |-> last_byte == `DLR_CH_CR;
   endproperty
   a_crlf: assert property (p_crlf) else $error("line feed without carriage return"); // RL13
   property p_empty;
      @(posedge clk_sys) disable iff (rst)
      (state == S_LF && push_ready && cmd == C_RETRIEVE && count == 32'h0) |=> state == S_EOF;
   endproperty
   a_empty: assert property (p_empty) else $error("empty log did not end at once"); // RL14
endmodule : dlr_responder

// ---- design/dlr_defs.svh ----
`ifndef DLR_DEFS_SVH
`define DLR_DEFS_SVH
// ********************************************************
// ascii bytes
// ********************************************************
`define DLR_CH_L     8'h4C
`define DLR_CH_X     8'h78
`define DLR_CH_8     8'h38
`define DLR_CH_5     8'h35
`define DLR_CH_6     8'h36
`define DLR_CH_0     8'h30
`define DLR_CH_COMMA 8'h2C
`define DLR_CH_CR    8'h0D
`define DLR_CH_LF    8'h0A
`define DLR_CH_E     8'h45
`define DLR_CH_O     8'h4F
`define DLR_CH_F     8'h46
// ********************************************************
// record layout and counts
// ********************************************************
`define DLR_PKT_LEN     32'h00000020
`define DLR_REC_LAST    5'h1F
`define DLR_SPARE_FIRST 5'h1C
`define DLR_SPARE_BYTE  8'hFF
`define DLR_PAD_BYTE    8'hFF
`define DLR_ECHO_LAST   5'h02
`define DLR_EOF_LAST    5'h04
`define DLR_LONG_POS    4'h9
`define DLR_SHORT_POS   4'h2
`define DLR_FIFO_WIDTH  8
`define DLR_FIFO_DEPTH  16
`endif

// ---- design/dlr_pkg.sv ----
package dlr_pkg;
   typedef enum logic [3:0] {
      S_IDLE, S_ECHO, S_NUM, S_SEP, S_CR, S_LF, S_FETCH, S_REC, S_WAIT, S_EOF
   } dlr_state_type;
   typedef enum logic [1:0] {
      C_RETRIEVE, C_VOLT, C_STATUS
   } dlr_cmd_type;
   typedef struct packed {
      logic [7:0]  rec_type;
      logic [7:0]  seconds;
      logic [7:0]  minutes;
      logic [7:0]  hours;
      logic [7:0]  weekday;
      logic [7:0]  date;
      logic [7:0]  month;
      logic [7:0]  year;
      logic [31:0] reading;
      logic [15:0] temp;
      logic [31:0] std_freq;
      logic [31:0] snow_reading;
      logic [31:0] snow_freq;
   } dlr_record_type;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } dlr_byte_type;
endpackage : dlr_pkg

// ---- testbench/dlr_host_model.sv ----
// ********************************************************
// host side of the character link
// ********************************************************
module dlr_host_model (
   input  wire logic            clk_sys,
   input  wire logic            rst,
   output dlr_pkg::dlr_byte_type rx,
   input  wire logic            tx_valid,
   input  wire logic [7:0]      tx_data,
   output logic                 tx_ready,
   input  wire logic            slow,
   input  wire logic            hold
);
   timeunit 1ns;
   timeprecision 100ps;
   import dlr_pkg::*;

   logic [7:0] got [$];

   initial rx = '{valid: 1'b0, data: 8'h00};
   initial tx_ready = 1'b0;

   // slow host takes a byte only every other cycle, hold stops it dead
   always @(posedge clk_sys)
   begin
      if (tx_valid && tx_ready)
         got.push_back(tx_data);
      tx_ready <= rst ? 1'b0 : hold ? 1'b0 : slow ? ~tx_ready : 1'b1;
   end

   task automatic send_byte(input logic [7:0] b);
      @(posedge clk_sys);
      rx <= '{valid: 1'b1, data: b};
      @(posedge clk_sys);
      // released line shows the inverse, never the old byte
      rx <= '{valid: 1'b0, data: ~b};
   endtask : send_byte
endmodule : dlr_host_model

// ---- testbench/tb_datalog_binary_retrieve_status.sv ----
`include "dlr_defs.svh"
`define CHK(got_v, exp_v) \
   begin \
      n_checks++; \
      if ((got_v) !== (exp_v)) \
      begin \
         errors++; \
         $display("Error at %0t: got %h expected %h", $time, got_v, exp_v); \
      end \
   end

module tb_datalog_binary_retrieve_status;
   timeunit 1ns;
   timeprecision 100ps;
   import dlr_pkg::*;

   logic           clk_sys = 1'b0;
   logic           rst = 1'b1;
   dlr_byte_type   rx;
   logic           tx_valid;
   logic [7:0]     tx_data;
   logic           tx_ready;
   logic [31:0]    rec_count = 32'h0;
   logic           rec_rd;
   logic [31:0]    rec_idx;
   logic           rec_valid = 1'b0;
   dlr_record_type rec_in;
   logic [7:0]     supply_adc = 8'h00;
   logic [7:0]     mem_status = 8'h00;
   logic           transfer_busy;
   logic           slow = 1'b0;
   logic           hold = 1'b0;
   logic [1:0]     rd_wait = 2'h0;
   int             errors = 0;
   int             n_checks = 0;
   logic [7:0]     exp_q [$];

   always #12.5 clk_sys = ~clk_sys;

   dlr_responder DUT (.clk_sys(clk_sys), .rst(rst), .rx(rx), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rec_count(rec_count), .rec_rd(rec_rd),
      .rec_idx(rec_idx), .rec_valid(rec_valid), .rec_in(rec_in),
      .supply_adc(supply_adc), .mem_status(mem_status), .transfer_busy(transfer_busy));

   dlr_host_model host (.clk_sys(clk_sys), .rst(rst), .rx(rx), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow), .hold(hold));

   // ********************************************************
   // record store: answers four cycles after each fetch
   // ********************************************************
   function automatic dlr_record_type rec_make(input logic [31:0] i);
      dlr_record_type r;
      r.rec_type     = (i[1:0] == 2'h1) ? 8'h11 : (i[1:0] == 2'h2) ? 8'h01 : 8'h10;
      r.seconds      = 8'h3B;
      r.minutes      = 8'h01 + i[7:0];
      r.hours        = 8'h17;
      r.weekday      = 8'h05;
      r.date         = 8'h1F;
      r.month        = 8'h0C;
      r.year         = 8'h63;
      r.reading      = 32'h01234567 + i;
      r.temp         = 16'hA1B2;
      r.std_freq     = 32'h89ABCDEF;
      r.snow_reading = 32'h13579BDF ^ i;
      r.snow_freq    = 32'h2468ACE0;
      return r;
   endfunction : rec_make

   always_comb rec_in = rec_make(rec_idx);

   always @(posedge clk_sys)
   begin
      rec_valid <= (rd_wait == 2'h1);
      rd_wait   <= rec_rd ? 2'h3 : (rd_wait != 2'h0) ? rd_wait - 2'h1 : 2'h0;
   end

   // ********************************************************
   // expectation helpers
   // ********************************************************
   task automatic push_str(input string s);
      foreach (s[i])
         exp_q.push_back(s[i]);
   endtask : push_str

   task automatic push_dec(input longint unsigned v, input int n);
      longint unsigned p;
      p = 1;
      repeat (n - 1) p *= 10;
      repeat (n)
      begin
         exp_q.push_back(8'h30 + 8'((v / p) % 10));
         p /= 10;
      end
   endtask : push_dec

   task automatic push_be32(input logic [31:0] v);
      for (int k = 3; k >= 0; k--)
         exp_q.push_back(v[8*k +: 8]);
   endtask : push_be32

   task automatic push_rec(input logic [31:0] i);
      dlr_record_type r;
      r = rec_make(i);
      exp_q.push_back(r.rec_type);
      exp_q.push_back(r.seconds);
      exp_q.push_back(r.minutes);
      exp_q.push_back(r.hours);
      exp_q.push_back(r.weekday);
      exp_q.push_back(r.date);
      exp_q.push_back(r.month);
      exp_q.push_back(r.year);
      push_be32(r.reading);
      exp_q.push_back(r.temp[15:8]);
      exp_q.push_back(r.temp[7:0]);
      exp_q.push_back(`DLR_PAD_BYTE);
      exp_q.push_back(`DLR_PAD_BYTE);
      push_be32(r.std_freq);
      push_be32(r.snow_reading);
      push_be32(r.snow_freq);
      push_be32(32'hFFFFFFFF);
   endtask : push_rec

   task automatic start_scn();
      exp_q.delete();
      host.got.delete();
   endtask : start_scn

   task automatic send_cmd(input logic [7:0] d);
      host.send_byte(`DLR_CH_L);
      host.send_byte(d);
      host.send_byte(`DLR_CH_X);
   endtask : send_cmd

   task automatic wait_len();
      int t;
      t = 0;
      while (host.got.size() < exp_q.size() && t < 4000)
      begin
         @(posedge clk_sys);
         t++;
      end
      repeat (40) @(posedge clk_sys);
   endtask : wait_len

   task automatic check_stream();
      wait_len();
      `CHK(host.got.size(), exp_q.size())
      foreach (exp_q[i])
         if (i < host.got.size())
            `CHK(host.got[i], exp_q[i])
      `CHK(transfer_busy, 1'b0)
   endtask : check_stream

   // ********************************************************
   // scenarios
   // ********************************************************
   task automatic scn_stray_prompt();
      start_scn();
      host.send_byte(8'h78);
      repeat (20) @(posedge clk_sys);
      `CHK(host.got.size(), 0)
   endtask : scn_stray_prompt

   task automatic scn_voltage();
      logic [7:0] vals [3];
      vals = '{8'h00, 8'hEE, 8'hFF};
      foreach (vals[i])
      begin
         start_scn();
         @(posedge clk_sys);
         supply_adc <= vals[i];
         send_cmd(`DLR_CH_5);
         push_str("L5,");
         push_dec(vals[i], 3);
         push_str("\r\n");
         check_stream();
      end
   endtask : scn_voltage

   task automatic scn_status();
      int polls;
      int val;
      polls = 0;
      val = 1;
      // poll until the busy bit reads clear
      while (val[0] && polls < 5)
      begin
         start_scn();
         @(posedge clk_sys);
         mem_status <= (polls < 2) ? 8'h81 : 8'hFE;
         send_cmd(`DLR_CH_6);
         push_str("L6,");
         push_dec((polls < 2) ? 8'h81 : 8'hFE, 3);
         push_str("\r\n");
         check_stream();
         val = (host.got[3] - 48) * 100 + (host.got[4] - 48) * 10 + host.got[5] - 48;
         polls++;
      end
      `CHK(polls, 3)
   endtask : scn_status

   task automatic scn_retrieve(input logic [31:0] n, input logic stall);
      start_scn();
      @(posedge clk_sys);
      rec_count <= n;
      slow <= stall;
      hold <= stall;
      send_cmd(`DLR_CH_8);
      push_str("L8,");
      push_dec(`DLR_PKT_LEN, 10);
      push_str(",");
      push_dec(n, 10);
      push_str("\r\n");
      if (n != 0)
         push_rec(0);
      if (stall)
      begin
         // consumer stalled: fifo fills and must keep its head
         repeat (60) @(posedge clk_sys);
         `CHK(tx_valid, 1'b1)
         `CHK(transfer_busy, 1'b1)
         hold <= 1'b0;
      end
      for (int i = 1; i < n; i++)
      begin
         wait_len();
         `CHK(host.got.size(), exp_q.size())
         host.send_byte(8'h78);
         push_rec(i);
      end
      push_str("EOF\r\n");
      check_stream();
      slow <= 1'b0;
   endtask : scn_retrieve

   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : tally_and_finish

   initial
   begin
      #1500000;
      errors++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial
   begin
      repeat (3) @(posedge clk_sys);
      rst <= 1'b0;
      scn_stray_prompt();
      scn_voltage();
      scn_status();
      scn_retrieve(32'h0, 1'b0);
      scn_retrieve(32'h3, 1'b1);
      scn_retrieve(32'h1, 1'b0);
      tally_and_finish();
   end
endmodule : tb_datalog_binary_retrieve_status
